// File: lin_transceiver_control.sv
// Control and diagnostics of a single-wire bus transceiver with an 8-bit
// serial register frame. Assumes all inputs are synchronous to i_clk and
// that analog fault detectors deliver clean levels.
`timescale 1ns/10ps
`include "lin_transceiver_control_params.svh"
module lin_transceiver_control
#(
    parameter int STUCK_CYCLES = `STUCK_TIME_MS * `CLK_KHZ,
    parameter int WAKE_CYCLES  = (`WAKE_FILTER_US * `CLK_KHZ + 999) / 1000
)
(
    // Clock and reset
    input  wire logic                            i_clk,
    input  wire logic                            i_rst_n,
    // Microcontroller transmit input and bus receiver level
    input  wire logic                            i_txd,
    input  wire logic                            i_bus_rx,
    // Analog fault detectors
    input  wire logic                            i_overcurrent,
    input  wire logic                            i_overtemp,
    input  wire logic                            i_rxd_short,
    // Summaries and status from neighbouring blocks
    input  wire logic [3:0]                      i_voltage_status,
    input  wire logic                            i_switch_summary,
    // Serial register port
    input  wire logic                            i_cs_n,
    input  wire logic                            i_sclk,
    input  wire logic                            i_mosi,
    output logic                                 o_miso,
    output logic                                 o_miso_oe,
    // Bus driver and receiver output
    output logic                                 o_tx_drive,
    output logic                                 o_rxd,
    output logic [1:0]                           o_slew_select,
    output logic                                 o_dominant_level_select,
    output logic                                 o_pullup_on,
    output logic                                 o_wake_thresh_sel,
    // System signals
    output logic                                 o_irq_n,
    output lin_transceiver_control_pkg::mode_t   o_mode,
    output logic                                 o_sleep_wake_reset
);
    import lin_transceiver_control_pkg::*;

    // Refuse cycle counts below one
    if (STUCK_CYCLES < 1 || WAKE_CYCLES < 1)
    begin : g_bad_counts
        $error("cycle counts must be at least one");
    end

    state_t r_reg;      // Registered state
    state_t r_next;     // Next state

    // Next-state logic
    always_comb
    begin
        logic       cs_fall;
        logic       cs_rise;
        logic       sclk_rise;
        logic       sclk_fall;
        logic       frame_ok;
        logic [3:0] addr;
        logic [3:0] data;
        logic [3:0] naddr;
        logic [3:0] stat;
        logic       rd_bus;
        logic       rd_isr;
        logic       set_stuck;
        logic       set_ot;
        logic       set_short;
        logic       set_oc;
        logic       rx_edge;
        logic       tx_en;
        logic       bus_sum;
        cs_fall   = r_reg.cs_q & ~i_cs_n;
        cs_rise   = ~r_reg.cs_q & i_cs_n;
        sclk_rise = ~i_cs_n & ~r_reg.sclk_q & i_sclk;
        sclk_fall = ~i_cs_n & r_reg.sclk_q & ~i_sclk;
        frame_ok  = cs_rise && (r_reg.bit_cnt == `FRAME_BITS);
        addr      = r_reg.rx_sh[7:4];
        data      = r_reg.rx_sh[3:0];
        naddr     = {r_reg.rx_sh[2:0], i_mosi};
        rd_bus    = frame_ok && (addr == `ADDR_BUS_CTRL || addr == `ADDR_BUS_STAT);
        rd_isr    = frame_ok && (addr == `ADDR_IRQ_MASK || addr == `ADDR_IRQ_SOURCE);
        rx_edge   = i_bus_rx ^ r_reg.rx_q;
        stat      = 4'h0;
        r_next    = r_reg;
        r_next.cs_q   = i_cs_n;
        r_next.sclk_q = i_sclk;
        r_next.rx_q   = i_bus_rx;

        // Stuck-dominant timer, restarted by every high transmit level
        if (i_txd)
        begin
            r_next.stuck_cnt = '0;
        end
        else if (r_reg.stuck_cnt < STUCK_CYCLES)
        begin
            r_next.stuck_cnt = r_reg.stuck_cnt + 32'h1;
        end
        set_stuck = ~i_txd && (r_reg.stuck_cnt == STUCK_CYCLES - 1);
        set_ot    = i_overtemp & ~r_reg.flags[`BSR_OT_BIT];
        set_short = i_rxd_short & ~r_reg.flags[`BSR_SHORT_BIT];
        set_oc    = i_overcurrent;

        // Status flags: a new event wins over a clearing read
        r_next.flags[`BSR_STUCK_BIT] = set_stuck
            | (r_reg.flags[`BSR_STUCK_BIT] & ~(rd_bus & i_txd));
        r_next.flags[`BSR_OT_BIT] = i_overtemp
            | (r_reg.flags[`BSR_OT_BIT] & ~rd_bus);
        r_next.flags[`BSR_SHORT_BIT] = i_rxd_short
            | (r_reg.flags[`BSR_SHORT_BIT] & ~rd_bus);
        r_next.flags[`BSR_OC_BIT] = set_oc
            | (r_reg.flags[`BSR_OC_BIT] & ~rd_bus);

        // Shutdown latches of the driver
        if (set_stuck)
        begin
            r_next.stuck_shut = 1'b1;
        end
        else if (i_txd)
        begin
            r_next.stuck_shut = 1'b0;
        end
        if (i_overtemp)
        begin
            r_next.ot_shut = 1'b1;
        end
        else if (i_txd || rd_bus)
        begin
            r_next.ot_shut = 1'b0;
        end
        if (i_rxd_short)
        begin
            r_next.short_shut = 1'b1;
        end
        else if (rx_edge && i_txd)
        begin
            r_next.short_shut = 1'b0;
        end

        // Serial frame: sample on falling, shift out on rising clock
        if (cs_fall)
        begin
            r_next.bit_cnt = '0;
            r_next.tx_sh   = {i_voltage_status != 4'h0, |r_reg.flags,
                              i_switch_summary, 5'h00};
        end
        else if (sclk_fall)
        begin
            r_next.rx_sh = {r_reg.rx_sh[6:0], i_mosi};
            if (r_reg.bit_cnt != 4'hf)
            begin
                r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
            end
            if (r_reg.bit_cnt == 4'h3)
            begin
                // Address complete: place the addressed status nibble
                if (naddr == `ADDR_MODE_CTRL || naddr == `ADDR_VOLT_STAT)
                begin
                    stat = i_voltage_status;
                end
                else if (naddr == `ADDR_BUS_CTRL || naddr == `ADDR_BUS_STAT)
                begin
                    stat = r_reg.flags;
                end
                else if (naddr == `ADDR_IRQ_MASK || naddr == `ADDR_IRQ_SOURCE)
                begin
                    stat = 4'h0;
                    stat[`SOURCE_WAKE_BIT] = r_reg.wake_pend;
                end
                else
                begin
                    stat = 4'h0;
                end
                r_next.tx_sh = {r_reg.tx_sh[7], stat, 3'h0};
            end
        end
        else if (sclk_rise && r_reg.bit_cnt != 4'h0)
        begin
            r_next.tx_sh = {r_reg.tx_sh[6:0], 1'b0};
        end

        // Register writes take effect at deselect of a valid frame
        if (frame_ok && addr == `ADDR_MODE_CTRL)
        begin
            r_next.pu_en = data[`MODE_PULLUP_BIT];
            if (r_reg.mode == MODE_NORMAL)
            begin
                case (data[1:0])
                    2'h1:    r_next.mode = MODE_STOP;
                    2'h2:    r_next.mode = MODE_SLEEP;
                    default: r_next.mode = MODE_NORMAL;
                endcase
                r_next.wake_en  = ~r_reg.rx_only;
                r_next.wake_cnt = '0;
            end
        end
        if (frame_ok && addr == `ADDR_BUS_CTRL)
        begin
            r_next.dls     = data[`BCR_DLS_BIT];
            r_next.rx_only = data[`BCR_RX_ONLY_BIT];
            r_next.slew    = data[1:0];
        end
        if (frame_ok && addr == `ADDR_IRQ_MASK)
        begin
            r_next.irq_mask = data[`MASK_BUS_BIT];
        end
        // Driver-stopping bus errors force receive-only, winning over a write;
        // over-current leaves the driver running, so it does not
        if (set_stuck | set_ot | set_short)
        begin
            r_next.rx_only = 1'b1;
        end

        // Bus wake filter in the low-power modes
        r_next.sleep_rst = 1'b0;
        r_next.wake_pend = r_reg.wake_pend & ~rd_isr;
        if (r_reg.mode != MODE_NORMAL && r_reg.wake_en)
        begin
            if (!i_bus_rx)
            begin
                if (r_reg.wake_cnt < WAKE_CYCLES)
                begin
                    r_next.wake_cnt = r_reg.wake_cnt + 32'h1;
                end
            end
            else if (!r_reg.rx_q && r_reg.wake_cnt >= WAKE_CYCLES)
            begin
                r_next.mode      = MODE_NORMAL;
                r_next.wake_pend = 1'b1;
                r_next.sleep_rst = (r_reg.mode == MODE_SLEEP);
                r_next.wake_cnt  = '0;
            end
            else
            begin
                r_next.wake_cnt = '0;
            end
        end

        // Output flops
        tx_en = (r_reg.mode == MODE_NORMAL) && !r_reg.rx_only
            && !r_reg.stuck_shut && !r_reg.ot_shut && !r_reg.short_shut;
        bus_sum = |r_reg.flags;
        r_next.tx_drive = tx_en & ~i_txd;
        if (r_reg.mode == MODE_NORMAL || (r_reg.mode == MODE_STOP && !r_reg.wake_en))
        begin
            r_next.rxd = i_bus_rx;
        end
        else
        begin
            r_next.rxd = 1'b1;
        end
        r_next.irq_n = ~((bus_sum & r_reg.irq_mask) | r_reg.wake_pend);
        r_next.pullup_on = (r_reg.mode == MODE_NORMAL) | r_reg.pu_en;
        r_next.miso      = r_next.tx_sh[7];
        r_next.miso_oe   = ~i_cs_n;
    end

    // State register with synchronous reset
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            r_reg          <= '0;
            r_reg.mode     <= MODE_NORMAL;
            r_reg.rx_only  <= `RST_RECEIVE_ONLY_BIT;
            r_reg.pu_en    <= `RST_PULLUP;
            r_reg.slew     <= `RST_SLEW;
            r_reg.dls      <= `RST_DLS;
            r_reg.irq_mask <= `RST_IRQ_MASK;
            r_reg.rx_q     <= 1'b1;
            r_reg.cs_q     <= 1'b1;
            r_reg.rxd      <= 1'b1;
            r_reg.irq_n    <= 1'b1;
            r_reg.pullup_on <= 1'b1;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from the state flops
    assign o_miso                  = r_reg.miso;
    assign o_miso_oe               = r_reg.miso_oe;
    assign o_tx_drive              = r_reg.tx_drive;
    assign o_rxd                   = r_reg.rxd;
    assign o_slew_select           = r_reg.slew;
    assign o_dominant_level_select = r_reg.dls;
    assign o_pullup_on             = r_reg.pullup_on;
    assign o_wake_thresh_sel       = r_reg.pu_en;
    assign o_irq_n                 = r_reg.irq_n;
    assign o_mode                  = r_reg.mode;
    assign o_sleep_wake_reset      = r_reg.sleep_rst;
endmodule

// File: lin_transceiver_control_params.svh
// Constants of the bus transceiver control block: offsets, bit positions,
// reset values and timing figures. Guarded, so any file of the block may include it.
`ifndef LIN_TRANSCEIVER_CONTROL_PARAMS_SVH
`define LIN_TRANSCEIVER_CONTROL_PARAMS_SVH
// Serial frame register addresses
`define ADDR_MODE_CTRL     4'h0
`define ADDR_VOLT_STAT     4'h1
`define ADDR_BUS_CTRL      4'h4
`define ADDR_BUS_STAT      4'h5
`define ADDR_IRQ_MASK      4'he
`define ADDR_IRQ_SOURCE    4'hf
// Bit positions of the bus status register
`define BSR_SHORT_BIT      3
`define BSR_STUCK_BIT      2
`define BSR_OT_BIT         1
`define BSR_OC_BIT         0
// Bit positions of control registers
`define BCR_DLS_BIT        3
`define BCR_RX_ONLY_BIT    2
`define MODE_PULLUP_BIT    2
`define MASK_BUS_BIT       1
`define SOURCE_WAKE_BIT    1
// Slew select encodings
`define SLEW_20K           2'h0
`define SLEW_10K4          2'h1
`define SLEW_FAST          2'h2
// Reset values
`define RST_SLEW           `SLEW_20K
`define RST_PULLUP         1'h1
`define RST_DLS            1'h0
`define RST_RECEIVE_ONLY_BIT         1'h0
`define RST_IRQ_MASK       1'h0
// Timing: clock rate, stuck-dominant time and wake filter time; then frame length in bits
`define CLK_KHZ            40000
`define STUCK_TIME_MS      1000
`define WAKE_FILTER_US     100
`define FRAME_BITS         4'h8
`endif

// File: lin_transceiver_control_pkg.sv
// Types of the bus transceiver control block.
// Assumes the params header sits in the same folder.
`include "lin_transceiver_control_params.svh"
package lin_transceiver_control_pkg;
    // Operating modes
    typedef enum logic [1:0] {MODE_NORMAL, MODE_STOP, MODE_SLEEP} mode_t;
    // Whole state of the block
    typedef struct packed {
        mode_t       mode;
        logic        rx_only;
        logic        pu_en;
        logic [1:0]  slew;
        logic        dls;
        logic        irq_mask;
        logic [3:0]  flags;
        logic        stuck_shut;
        logic        ot_shut;
        logic        short_shut;
        logic [31:0] stuck_cnt;
        logic [31:0] wake_cnt;
        logic        wake_en;
        logic        wake_pend;
        logic        rx_q;
        logic        cs_q;
        logic        sclk_q;
        logic [3:0]  bit_cnt;
        logic [7:0]  rx_sh;
        logic [7:0]  tx_sh;
        logic        tx_drive;
        logic        rxd;
        logic        irq_n;
        logic        miso;
        logic        miso_oe;
        logic        pullup_on;
        logic        sleep_rst;
    } state_t;
endpackage

// File: spi_master_model.sv
// Serial master standing for the microcontroller side of the register port.
// Assumes the slave samples data on the falling serial clock edge.
`timescale 1ns/10ps
module spi_master_model
(
    // Clock and reply line
    input  wire logic i_clk,
    input  wire logic i_miso,
    // Serial lines towards the slave
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_mosi
);
    // Idle: deselected, clock still
    initial
    begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_mosi = 1'b0;
    end

    // Released data line toggles so a stale level is never mistaken
    always @(posedge i_clk)
        if (o_cs_n)
            o_mosi <= ~o_mosi;

    // One frame, address nibble then control nibble, MSB first
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        @(posedge i_clk) o_cs_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        // Data moves on the rise, both sides sample on the fall
        for (int i = 0; i < nbits; i++)
        begin
            o_sclk <= 1'b1;
            o_mosi <= tx[7 - i];
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b0;
            rx = {rx[6:0], i_miso};
            repeat (4) @(posedge i_clk);
        end
        o_cs_n <= 1'b1;
        repeat (4) @(posedge i_clk);
    endtask
endmodule

// File: lin_transceiver_control_asserts.sv
// Timing checks on the ports of the bus transceiver control block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module lin_transceiver_control_asserts
import lin_transceiver_control_pkg::*;
#(
    parameter int STUCK_CYCLES = 50,
    parameter int WAKE_CYCLES  = 10
)
(
    // Clock, reset and watched ports
    input wire logic  i_clk,
    input wire logic  i_rst_n,
    input wire logic  i_txd,
    input wire logic  i_overtemp,
    input wire logic  i_rxd_short,
    input wire logic  i_cs_n,
    input wire logic  o_miso_oe,
    input wire logic  o_tx_drive,
    input wire logic  o_pullup_on,
    input wire logic  o_wake_thresh_sel,
    input wire mode_t o_mode,
    input wire logic  o_sleep_wake_reset
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    logic [31:0] low_cnt_reg;  // Cycles with transmit held dominant
    logic [31:0] low_cnt_next;

    // Run length restarts whenever transmit goes recessive
    always_comb
        low_cnt_next = i_txd ? 32'h0 : low_cnt_reg + 32'h1;

    // Counter register
    always_ff @(posedge i_clk)
        if (!i_rst_n)
            low_cnt_reg <= 32'h0;
        else
            low_cnt_reg <= low_cnt_next;

    idle_release_a: assert property (i_txd |=> !o_tx_drive)
        else $error("driver active with transmit recessive");
    hot_shut_a: assert property (i_overtemp [*3] |-> !o_tx_drive)
        else $error("driver active during over-temperature");
    short_shut_a: assert property (i_rxd_short [*3] |-> !o_tx_drive)
        else $error("driver active during receive short");
    stuck_shut_a: assert property (low_cnt_reg > STUCK_CYCLES + 2 |-> !o_tx_drive)
        else $error("driver active after stuck dominant time");
    lowpower_off_a: assert property ((o_mode != MODE_NORMAL) [*2] |-> !o_tx_drive)
        else $error("driver active in low-power mode");
    oe_hold_a: assert property (!i_cs_n [*3] |-> o_miso_oe)
        else $error("reply line not driven while selected");
    oe_end_a: assert property (i_cs_n [*3] |-> !o_miso_oe)
        else $error("reply line driven while deselected");
    wake_pulse_a: assert property (o_sleep_wake_reset |=> !o_sleep_wake_reset)
        else $error("wake reset longer than one cycle");
    pullup_sel_a: assert property ((o_mode != MODE_NORMAL) [*2] |->
        o_pullup_on == o_wake_thresh_sel)
        else $error("pull-up and wake threshold disagree");
endmodule

bind lin_transceiver_control lin_transceiver_control_asserts #(
    .STUCK_CYCLES(STUCK_CYCLES), .WAKE_CYCLES(WAKE_CYCLES)) u_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_txd(i_txd), .i_overtemp(i_overtemp),
    .i_rxd_short(i_rxd_short), .i_cs_n(i_cs_n), .o_miso_oe(o_miso_oe),
    .o_tx_drive(o_tx_drive), .o_pullup_on(o_pullup_on),
    .o_wake_thresh_sel(o_wake_thresh_sel), .o_mode(o_mode),
    .o_sleep_wake_reset(o_sleep_wake_reset));

// File: lin_transceiver_control_tb.sv
// Self-checking bench of the bus transceiver control block.
// Assumes the serial master model and the checker are compiled first.
`timescale 1ns/10ps
`include "lin_transceiver_control_params.svh"
`define CHK(name, exp, got) \
    begin compares++; if ((got) !== (exp)) begin err_count++; \
    $display("MISMATCH %s expected %0h seen %0h", name, exp, got); end end
module lin_transceiver_control_tb;
    import lin_transceiver_control_pkg::*;
    localparam int STUCK = 300;  // Shortened stuck-dominant time
    localparam int WAKE  = 10;   // Shortened wake filter time
    // Bench-driven inputs
    logic       i_clk    = 1'b0;
    logic       i_rst_n  = 1'b0;
    logic       i_txd    = 1'b1;
    logic       i_bus_rx = 1'b1;
    logic [3:0] fault    = 4'h0;  // {short, unused, overtemp, overcurrent}
    logic [3:0] volt     = 4'h0;
    logic       sw_sum   = 1'b0;
    // Serial lines and outputs
    logic       cs_n, sclk, mosi, miso, miso_oe, tx_drive, rxd, dls;
    logic       pullup_on, thresh, irq_n, sleep_rst;
    logic [1:0] slew;
    mode_t      mode;
    logic [7:0] rx;
    logic       seen;
    int         err_count = 0;
    int         compares  = 0;

    // 40 MHz clock
    always #12.5 i_clk = ~i_clk;

    lin_transceiver_control #(.STUCK_CYCLES(STUCK), .WAKE_CYCLES(WAKE)) dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_txd(i_txd), .i_bus_rx(i_bus_rx),
        .i_overcurrent(fault[0]), .i_overtemp(fault[1]), .i_rxd_short(fault[3]),
        .i_voltage_status(volt), .i_switch_summary(sw_sum), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe),
        .o_tx_drive(tx_drive), .o_rxd(rxd), .o_slew_select(slew),
        .o_dominant_level_select(dls), .o_pullup_on(pullup_on),
        .o_wake_thresh_sel(thresh), .o_irq_n(irq_n), .o_mode(mode),
        .o_sleep_wake_reset(sleep_rst));

    spi_master_model master (.i_clk(i_clk), .i_miso(miso), .o_cs_n(cs_n),
        .o_sclk(sclk), .o_mosi(mosi));

    // Helpers: wait, one full frame, transmit-low probe of the driver
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic frame(input logic [3:0] a, input logic [3:0] c);
        master.xfer({a, c}, 8, rx);
    endtask
    task automatic chk_drive(input logic exp);
        i_txd <= 1'b0;
        tick(3);
        `CHK("tx_drive", exp, tx_drive)
        i_txd <= 1'b1;
        tick(2);
    endtask
    task automatic bus_pulse(input int n);
        i_bus_rx <= 1'b0;
        tick(n);
        i_bus_rx <= 1'b1;
        tick(4);
    endtask

    // Reset for 8 cycles, then reset values
    task automatic t_reset;
        i_rst_n <= 1'b0;
        tick(8);
        i_rst_n <= 1'b1;
        tick(3);
        `CHK("slew", `SLEW_20K, slew)
        `CHK("pullup", 1'b1, pullup_on)
        `CHK("threshold", 1'b1, thresh)
        `CHK("dls", 1'b0, dls)
        `CHK("irq", 1'b1, irq_n)
        `CHK("mode", MODE_NORMAL, mode)
    endtask

    // Every slew code and both levels, then a short frame that must be ignored
    task automatic t_config;
        for (int i = 0; i < 3; i++)
        begin
            frame(`ADDR_BUS_CTRL, {i[0], 1'b0, i[1:0]});
            `CHK("slew", i[1:0], slew)
            `CHK("dls", i[0], dls)
        end
        master.xfer({`ADDR_BUS_CTRL, 4'h9}, 7, rx);
        `CHK("refused", 2'h2, slew)
        frame(`ADDR_BUS_CTRL, 4'h0);
        chk_drive(1'b1);
        frame(`ADDR_BUS_CTRL, 4'h4);
        chk_drive(1'b0);
        frame(`ADDR_BUS_CTRL, 4'h0);
    endtask

    // Summary bits and status nibble of a voltage read
    task automatic t_summary;
        volt <= 4'h9;
        sw_sum <= 1'b1;
        frame(`ADDR_VOLT_STAT, 4'h0);
        `CHK("reply", 8'ha9, rx)
        volt <= 4'h0;
        sw_sum <= 1'b0;
        frame(`ADDR_VOLT_STAT, 4'h0);
        `CHK("reply", 8'h00, rx)
    endtask

    // One bus fault: mask, flag, shutdown, clearing read and restart
    task automatic t_fault(input int k);
        frame(`ADDR_IRQ_MASK, 4'h0);
        fault[k] <= 1'b1;
        tick(3);
        `CHK("irq masked", 1'b1, irq_n)
        frame(`ADDR_IRQ_MASK, 4'h2);
        `CHK("irq", 1'b0, irq_n)
        chk_drive(k == 0);
        frame(`ADDR_BUS_STAT, 4'h0);
        `CHK("flags", 4'h1 << k, rx[3:0])
        `CHK("bus summary", 1'b1, rx[6])
        fault[k] <= 1'b0;
        bus_pulse(2);
        frame(`ADDR_BUS_STAT, 4'h0);
        frame(`ADDR_BUS_STAT, 4'h0);
        `CHK("cleared", 4'h0, rx[3:0])
        `CHK("irq", 1'b1, irq_n)
        chk_drive(k == 0);
        frame(`ADDR_BUS_CTRL, 4'h0);
        chk_drive(1'b1);
    endtask

    // Dominant run broken once, then held past the limit
    task automatic t_stuck;
        i_txd <= 1'b0;
        tick(STUCK - 20);
        i_txd <= 1'b1;
        tick(1);
        i_txd <= 1'b0;
        tick(STUCK - 20);
        `CHK("restart", 1'b1, tx_drive)
        tick(30);
        `CHK("stuck", 1'b0, tx_drive)
        frame(`ADDR_BUS_STAT, 4'h0);
        frame(`ADDR_BUS_STAT, 4'h0);
        `CHK("kept", 4'h4, rx[3:0])
        i_txd <= 1'b1;
        frame(`ADDR_BUS_STAT, 4'h0);
        frame(`ADDR_BUS_STAT, 4'h0);
        `CHK("cleared", 4'h0, rx[3:0])
        frame(`ADDR_BUS_CTRL, 4'h0);
        chk_drive(1'b1);
    endtask

    // Stop: short pulse filtered, long pulse wakes with interrupt
    task automatic t_stop;
        frame(`ADDR_MODE_CTRL, 4'h5);
        `CHK("mode", MODE_STOP, mode)
        chk_drive(1'b0);
        bus_pulse(WAKE - 5);
        `CHK("filtered", MODE_STOP, mode)
        bus_pulse(WAKE + 5);
        `CHK("woken", MODE_NORMAL, mode)
        `CHK("irq", 1'b0, irq_n)
        frame(`ADDR_IRQ_SOURCE, 4'h0);
        `CHK("source", 4'h2, rx[3:0])
        frame(`ADDR_IRQ_SOURCE, 4'h0);
        `CHK("source", 4'h0, rx[3:0])
    endtask

    // Sleep without pull-up: wake through a reset pulse
    task automatic t_sleep;
        frame(`ADDR_MODE_CTRL, 4'h2);
        `CHK("mode", MODE_SLEEP, mode)
        `CHK("pullup", 1'b0, pullup_on)
        `CHK("threshold", 1'b0, thresh)
        chk_drive(1'b0);
        seen = 1'b0;
        i_bus_rx <= 1'b0;
        tick(WAKE + 5);
        i_bus_rx <= 1'b1;
        repeat (20) @(posedge i_clk) if (sleep_rst === 1'b1) seen = 1'b1;
        `CHK("wake reset", 1'b1, seen)
        frame(`ADDR_IRQ_SOURCE, 4'h0);
        `CHK("source", 4'h2, rx[3:0])
        frame(`ADDR_MODE_CTRL, 4'h4);
    endtask

    // Receive-only stop: no bus wake, receive output follows the bus
    task automatic t_receive_only_bit_stop;
        frame(`ADDR_BUS_CTRL, 4'hd);
        frame(`ADDR_MODE_CTRL, 4'h5);
        bus_pulse(WAKE + 5);
        `CHK("no wake", MODE_STOP, mode)
        i_bus_rx <= 1'b0;
        tick(3);
        `CHK("rxd", 1'b0, rxd)
        i_bus_rx <= 1'b1;
        tick(3);
        `CHK("rxd", 1'b1, rxd)
    endtask

    // Closing report and verdict
    task automatic print_verdict;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog against a hang
    initial
    begin
        #(25 * 30000);
        err_count++;
        print_verdict;
    end

    // Main sequence
    initial
    begin
        @(posedge i_clk);
        t_reset;
        t_config;
        t_summary;
        t_fault(0);
        t_fault(1);
        t_fault(3);
        t_stuck;
        t_stop;
        t_sleep;
        t_receive_only_bit_stop;
        t_reset;
        print_verdict;
    end
endmodule
